// *** hdl/sttsa_consts.svh ***
// Constants of the serial time slot assigner: offsets, codes, field positions, reset values
`ifndef STTSA_CONSTS_SVH
`define STTSA_CONSTS_SVH

// Register word offsets (byte addresses on the register bus)
`define STTSA_OFS_RX_CSR      5'h00
`define STTSA_OFS_TX_CSR      5'h04
`define STTSA_OFS_RX_ICR      5'h08
`define STTSA_OFS_TX_ICR      5'h0c
`define STTSA_OFS_PCR         5'h10
`define STTSA_OFS_LSB         2
`define STTSA_OFS_MSB         4

// Command field in bits 15-12 of a command/status register
`define STTSA_CMD_MSB         15
`define STTSA_CMD_LSB         12
`define STTSA_CMD_SEL_GROUP   2'h1

// Upper byte of an interrupt control register
`define STTSA_ICR_STEER_BIT   8
`define STTSA_ICR_SLOT_MSB    15
`define STTSA_ICR_SLOT_LSB    9
`define STTSA_ICR_OFF_MSB     15
`define STTSA_ICR_OFF_LSB     13
`define STTSA_ICR_CNT_MSB     12
`define STTSA_ICR_CNT_LSB     9

// Gate pin mode fields of the port control register
`define STTSA_PCR_TXG_MSB     9
`define STTSA_PCR_TXG_LSB     8
`define STTSA_PCR_RXG_MSB     7
`define STTSA_PCR_RXG_LSB     6
`define STTSA_PIN_MODE_GATE   2'h1

// Reset values
`define STTSA_RST_PCR         16'h0000
`define STTSA_RST_BYTE        8'h00
`define STTSA_RST_SLOT        7'h00
`define STTSA_RST_OFF         3'h0
`define STTSA_RST_CNT         4'h0
`define STTSA_RST_DATA        32'h0000_0000

`endif

// *** hdl/sttsa_pkg.sv ***
// Types of the serial time slot assigner
package sttsa_pkg;

  // Selection of the upper byte of an interrupt control register
  typedef enum logic [1:0] {
    STTSA_SEL_TSA = 2'b00,
    STTSA_SEL_CUR = 2'b01,
    STTSA_SEL_IRQ = 2'b10,
    STTSA_SEL_DMA = 2'b11
  } sttsa_sel_t;

  // One assigner with its registers and bit clock synchroniser
  typedef struct packed {
    sttsa_sel_t  sel;
    logic [6:0]  slot;
    logic [2:0]  off;
    logic [3:0]  cnt;
    logic [7:0]  lvl_irq;
    logic [7:0]  lvl_dma;
    logic [7:0]  low;
    logic [9:0]  blk;
    logic [6:0]  pas;
    logic        win;
    logic        gclk;
    logic        gate_n;
    logic        c1;
    logic        c2;
    logic        cd;
  } sttsa_side_t;

  // State of the top module, apart from the two reset synchroniser flip-flops
  typedef struct packed {
    sttsa_side_t rx;
    sttsa_side_t tx;
    logic        fs1;
    logic        fs2;
    logic [15:0] port_pin_control;
    logic        txoe;
    logic        rxoe;
    logic        waitreq;
    logic [31:0] rdata;
  } sttsa_state_t;

endpackage

// *** hdl/sttsa_top.sv ***
// Receive and transmit time slot assigners with Avalon-MM register slave
`timescale 1ns/1ps
`include "sttsa_consts.svh"

module sttsa_top (
  input  wire logic        sys_clk,           // System clock, 25 MHz
  input  wire logic        rst_n,             // Asynchronous reset, active low
  input  wire logic [4:0]  avs_address,       // Register byte address
  input  wire logic        avs_read,          // Read request
  input  wire logic        avs_write,         // Write request
  input  wire logic [3:0]  avs_byteenable,    // Byte lanes of the access
  input  wire logic [31:0] avs_writedata,     // Write data
  output logic      [31:0] avs_readdata,      // Read data
  output logic             avs_waitrequest,   // Slave not ready
  input  wire logic [7:0]  rx_fifo_level,     // Current receive FIFO level
  input  wire logic [7:0]  tx_fifo_level,     // Current transmit FIFO level
  input  wire logic        rx_bit_clock,      // Receive bit clock pin
  input  wire logic        tx_bit_clock,      // Transmit bit clock pin
  input  wire logic        frame_sync_in,     // Frame sync pin, active low
  output logic             rx_clk_gated,      // Bit clock to the receiver
  output logic             tx_clk_gated,      // Bit clock to the transmitter
  output logic             tx_gate_n,         // Transmit gate pin level
  output logic             tx_gate_oe,        // Transmit gate pin driven
  output logic             rx_gate_n,         // Receive gate pin level
  output logic             rx_gate_oe         // Receive gate pin driven
);

  logic                  rst_m_r;
  logic                  rst_s_r;
  sttsa_pkg::sttsa_state_t st_r;
  sttsa_pkg::sttsa_state_t st_nxt;

  // Advance one assigner by one system clock
  function automatic sttsa_pkg::sttsa_side_t assign_step(
    input sttsa_pkg::sttsa_side_t s,
    input logic                   clk_pin,
    input logic                   fs_low
  );
    sttsa_pkg::sttsa_side_t n;
    logic                   rise;
    n    = s;
    n.c1 = clk_pin;
    n.c2 = s.c1;
    n.cd = s.c2;
    rise = s.c2 & ~s.cd;
    if (s.cnt == `STTSA_RST_CNT) begin
      // Feature off: clock passes untouched
      n.blk = '0;
      n.pas = '0;
      n.win = 1'b1;
    end else if (rise) begin
      if (fs_low) begin
        // A new frame always reloads, even inside a window
        n.blk = {s.slot, s.off};
        n.pas = {s.cnt, 3'h0};
        n.win = 1'b0;
      end else if (s.blk != '0) begin
        n.blk = s.blk - 10'h001;
        n.win = 1'b0;
      end else if (s.pas != '0) begin
        // Zero block count falls through here on the edge after the sync edge
        n.pas = s.pas - 7'h01;
        n.win = 1'b1;
      end else begin
        n.win = 1'b0;
      end
    end
    n.gclk   = s.c2 & n.win;
    n.gate_n = ~n.win;
    return n;
  endfunction

  // Read of a command/status register
  function automatic logic [31:0] csr_read(
    input sttsa_pkg::sttsa_side_t s
  );
    logic [31:0] v;
    v = `STTSA_RST_DATA;
    v[`STTSA_CMD_MSB:`STTSA_CMD_LSB] = {`STTSA_CMD_SEL_GROUP, s.sel};
    v[1] = s.win;
    v[0] = (s.blk != '0);
    return v;
  endfunction

  // Read of an interrupt control register
  function automatic logic [31:0] icr_read(
    input sttsa_pkg::sttsa_side_t s,
    input logic [7:0]             level
  );
    logic [31:0] v;
    v      = `STTSA_RST_DATA;
    v[7:0] = s.low;
    unique case (s.sel)
      sttsa_pkg::STTSA_SEL_TSA: v[15:8] = {s.slot, 1'b0};
      sttsa_pkg::STTSA_SEL_CUR: v[15:8] = level;
      sttsa_pkg::STTSA_SEL_IRQ: v[15:8] = s.lvl_irq;
      sttsa_pkg::STTSA_SEL_DMA: v[15:8] = s.lvl_dma;
    endcase
    return v;
  endfunction

  // Write of a command/status register
  function automatic sttsa_pkg::sttsa_side_t csr_write(
    input sttsa_pkg::sttsa_side_t s,
    input logic [31:0]            d,
    input logic [3:0]             be
  );
    sttsa_pkg::sttsa_side_t n;
    logic [3:0]             cmd;
    n   = s;
    cmd = d[`STTSA_CMD_MSB:`STTSA_CMD_LSB];
    // Only the four selection commands change the selection
    if (be[1] && cmd[3:2] == `STTSA_CMD_SEL_GROUP) begin
      n.sel = sttsa_pkg::sttsa_sel_t'(cmd[1:0]);
    end
    return n;
  endfunction

  // Write of an interrupt control register
  function automatic sttsa_pkg::sttsa_side_t icr_write(
    input sttsa_pkg::sttsa_side_t s,
    input logic [31:0]            d,
    input logic [3:0]             be
  );
    sttsa_pkg::sttsa_side_t n;
    n = s;
    if (be[0]) begin
      n.low = d[7:0];
    end
    if (be[1]) begin
      unique case (s.sel)
        sttsa_pkg::STTSA_SEL_TSA: begin
          if (!d[`STTSA_ICR_STEER_BIT]) begin
            n.slot = d[`STTSA_ICR_SLOT_MSB:`STTSA_ICR_SLOT_LSB];
          end else begin
            n.off = d[`STTSA_ICR_OFF_MSB:`STTSA_ICR_OFF_LSB];
            n.cnt = d[`STTSA_ICR_CNT_MSB:`STTSA_ICR_CNT_LSB];
          end
        end
        sttsa_pkg::STTSA_SEL_CUR: n.low = n.low;
        sttsa_pkg::STTSA_SEL_IRQ: n.lvl_irq = d[15:8];
        sttsa_pkg::STTSA_SEL_DMA: n.lvl_dma = d[15:8];
      endcase
    end
    return n;
  endfunction

  // Reset values of one assigner
  function automatic sttsa_pkg::sttsa_side_t side_reset();
    sttsa_pkg::sttsa_side_t n;
    n         = '0;
    n.sel     = sttsa_pkg::STTSA_SEL_CUR;
    n.slot    = `STTSA_RST_SLOT;
    n.off     = `STTSA_RST_OFF;
    n.cnt     = `STTSA_RST_CNT;
    n.lvl_irq = `STTSA_RST_BYTE;
    n.lvl_dma = `STTSA_RST_BYTE;
    n.low     = `STTSA_RST_BYTE;
    n.gate_n  = 1'b1;
    return n;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  always_comb begin
    logic        fs_low;
    logic        req;
    logic [31:0] rd;
    fs_low = 1'b0;
    req    = 1'b0;
    rd     = `STTSA_RST_DATA;
    st_nxt = st_r;

    // Frame sync pin synchroniser; sampled on each system clock, used on each bit clock rise
    st_nxt.fs1 = frame_sync_in;
    st_nxt.fs2 = st_r.fs1;
    fs_low     = ~st_r.fs2;

    st_nxt.rx = assign_step(st_r.rx, rx_bit_clock, fs_low);
    st_nxt.tx = assign_step(st_r.tx, tx_bit_clock, fs_low);

    // Gate pins driven only in gate pin mode
    st_nxt.txoe = (st_r.port_pin_control[`STTSA_PCR_TXG_MSB:`STTSA_PCR_TXG_LSB]
                   == `STTSA_PIN_MODE_GATE);
    st_nxt.rxoe = (st_r.port_pin_control[`STTSA_PCR_RXG_MSB:`STTSA_PCR_RXG_LSB]
                   == `STTSA_PIN_MODE_GATE);

    // Read mux
    unique case (avs_address)
      `STTSA_OFS_RX_CSR: rd = csr_read(st_r.rx);
      `STTSA_OFS_TX_CSR: rd = csr_read(st_r.tx);
      `STTSA_OFS_RX_ICR: rd = icr_read(st_r.rx, rx_fifo_level);
      `STTSA_OFS_TX_ICR: rd = icr_read(st_r.tx, tx_fifo_level);
      `STTSA_OFS_PCR:    rd = {16'h0000, st_r.port_pin_control};
      default:           rd = `STTSA_RST_DATA;
    endcase

    // One wait state: answer is ready one cycle after the request
    req = avs_read | avs_write;
    if (req && st_r.waitreq) begin
      st_nxt.waitreq = 1'b0;
      st_nxt.rdata   = avs_read ? rd : `STTSA_RST_DATA;
    end else begin
      // Read data stands only in the answer cycle
      st_nxt.waitreq = 1'b1;
      st_nxt.rdata   = `STTSA_RST_DATA;
      if (avs_write && !st_r.waitreq) begin
        unique case (avs_address)
          `STTSA_OFS_RX_CSR: st_nxt.rx = csr_write(st_nxt.rx, avs_writedata, avs_byteenable);
          `STTSA_OFS_TX_CSR: st_nxt.tx = csr_write(st_nxt.tx, avs_writedata, avs_byteenable);
          `STTSA_OFS_RX_ICR: st_nxt.rx = icr_write(st_nxt.rx, avs_writedata, avs_byteenable);
          `STTSA_OFS_TX_ICR: st_nxt.tx = icr_write(st_nxt.tx, avs_writedata, avs_byteenable);
          `STTSA_OFS_PCR: begin
            if (avs_byteenable[0]) begin
              st_nxt.port_pin_control[7:0] = avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
              st_nxt.port_pin_control[15:8] = avs_writedata[15:8];
            end
          end
          default: st_nxt.port_pin_control = st_r.port_pin_control;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      st_r         <= '0;
      st_r.rx      <= side_reset();
      st_r.tx      <= side_reset();
      st_r.fs1     <= 1'b1;
      st_r.fs2     <= 1'b1;
      st_r.port_pin_control     <= `STTSA_RST_PCR;
      st_r.waitreq <= 1'b1;
      st_r.rdata   <= `STTSA_RST_DATA;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata    = st_r.rdata;
  assign avs_waitrequest = st_r.waitreq;
  assign rx_clk_gated    = st_r.rx.gclk;
  assign tx_clk_gated    = st_r.tx.gclk;
  assign tx_gate_n       = st_r.tx.gate_n;
  assign rx_gate_n       = st_r.rx.gate_n;
  assign tx_gate_oe      = st_r.txoe;
  assign rx_gate_oe      = st_r.rxoe;

endmodule

// *** verification/sttsa_link.sv ***
// Frame sync and bit clock source standing in for the multiplexed link
`timescale 1ns/1ps
module sttsa_link (
  output logic bclk,  // Bit clock, still between frames
  output logic fs_n   // Frame sync, active low
);
  initial begin
    bclk = 1'b0;
    fs_n = 1'b1;
  end
  // One frame of n bit clocks; sync stays low across the first rise only
  task automatic frame(input int n);
    #7;
    fs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #160 bclk = 1'b1;
      #160 bclk = 1'b0;
      fs_n = 1'b1;
    end
  endtask
endmodule

// *** verification/sttsa_chk.sv ***
// Concurrent checks on the time slot assigner ports
`timescale 1ns/1ps
module sttsa_chk (
  input wire logic        sys_clk,          // Clock
  input wire logic        rst_n,            // Reset, active low
  input wire logic        avs_read,         // Read request
  input wire logic        avs_write,        // Write request
  input wire logic [31:0] avs_readdata,     // Read data
  input wire logic        avs_waitrequest,  // Slave not ready
  input wire logic        rx_clk_gated,     // Gated receive clock
  input wire logic        tx_clk_gated,     // Gated transmit clock
  input wire logic        rx_gate_n,        // Receive gate
  input wire logic        tx_gate_n,        // Transmit gate
  input wire logic        rx_gate_oe,       // Receive gate driven
  input wire logic        tx_gate_oe        // Transmit gate driven
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  rdata_idle_a: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data not zero outside answer");
  rdata_upper_a: assert property (avs_readdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  rx_window_a: assert property ($rose(rx_clk_gated) |-> ##[0:1] !rx_gate_n)
    else $error("receive clock passed outside gate");
  tx_window_a: assert property ($rose(tx_clk_gated) |-> ##[0:1] !tx_gate_n)
    else $error("transmit clock passed outside gate");
  pin_mode_a: assert property ($changed({rx_gate_oe, tx_gate_oe}) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("gate enable changed without a write");
  cover property ($fell(rx_gate_n));
  cover property ($fell(tx_gate_n));
  cover property (avs_read && !avs_waitrequest);
endmodule
bind sttsa_top sttsa_chk chk (.sys_clk, .rst_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .rx_clk_gated, .tx_clk_gated, .rx_gate_n, .tx_gate_n, .rx_gate_oe, .tx_gate_oe);

// *** verification/tb_top.sv ***
// Self-checking bench for the serial time slot assigner
`timescale 1ns/1ps
`include "sttsa_consts.svh"
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [4:0]  adr     = 5'h00;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wd      = 32'h0;
  logic [31:0] rdata, q;
  logic        wreq, bclk, fs_n, rxg, txg, txgn, txoe, rxgn, rxoe;
  int          num_errors = 0;
  int          checks     = 0;
  int          cyc        = 0;
  int          idx = 0, rx_n = 0, tx_n = 0, rx_1st = 0, tx_1st = 0;

  always #20 sys_clk = ~sys_clk;
  sttsa_link link (.bclk(bclk), .fs_n(fs_n));
  sttsa_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_byteenable(4'h3), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .rx_fifo_level(8'h5a), .tx_fifo_level(8'ha5), .rx_bit_clock(bclk), .tx_bit_clock(bclk),
    .frame_sync_in(fs_n), .rx_clk_gated(rxg), .tx_clk_gated(txg), .tx_gate_n(txgn), .tx_gate_oe(txoe),
    .rx_gate_n(rxgn), .rx_gate_oe(rxoe));

  // Bit index within the frame; the sync rise is index 0
  always @(posedge bclk) idx = (fs_n === 1'b0) ? 0 : idx + 1;
  always @(posedge rxg) begin
    if (rx_n == 0) rx_1st = idx;
    rx_n++;
  end
  always @(posedge txg) begin
    if (tx_n == 0) tx_1st = idx;
    tx_n++;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do @(posedge sys_clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic prog(input logic [4:0] a, input logic [6:0] s, input logic [2:0] o, input logic [3:0] c);
    bus(1'b1, a - 5'h08, 32'h0000_4000);
    bus(1'b1, a, {16'h0, s, 1'b0, 8'h11});
    bus(1'b1, a, {16'h0, o, c, 1'b1, 8'h11});
    bus(1'b0, a, 32'h0);
    cmp(q, {16'h0, s, 1'b0, 8'h11});
  endtask

  task automatic run(input int n);
    rx_n = 0;
    tx_n = 0;
    link.frame(n);
    repeat (10) @(posedge sys_clk);
  endtask

  task automatic t_reset;
    bus(1'b0, `STTSA_OFS_RX_ICR, 32'h0);
    cmp(q, 32'h0000_5a00);
    bus(1'b0, `STTSA_OFS_TX_ICR, 32'h0);
    cmp(q, 32'h0000_a500);
    bus(1'b0, `STTSA_OFS_PCR, 32'h0);
    cmp(q, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    cmp(q, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_select;
    for (int c = 7; c >= 5; c--) begin
      bus(1'b1, `STTSA_OFS_RX_CSR, 32'(c) << 12);
      bus(1'b0, `STTSA_OFS_RX_CSR, 32'h0);
      cmp(q & 32'hf000, 32'(c) << 12);
      bus(1'b1, `STTSA_OFS_RX_ICR, 32'h0000_3c11);
      bus(1'b0, `STTSA_OFS_RX_ICR, 32'h0);
      cmp(q, (c == 5) ? 32'h0000_5a11 : 32'h0000_3c11);
    end
    prog(`STTSA_OFS_RX_ICR, 7'h05, 3'h0, 4'h0);
    bus(1'b1, `STTSA_OFS_RX_CSR, 32'h0000_6000);
    bus(1'b0, `STTSA_OFS_RX_ICR, 32'h0);
    cmp(q, 32'h0000_3c11);
    $display("test select done");
  endtask

  task automatic t_frames;
    bus(1'b1, `STTSA_OFS_PCR, 32'h0000_0140);
    repeat (2) @(posedge sys_clk);
    cmp({30'h0, txoe, rxoe}, 32'h3);
    prog(`STTSA_OFS_RX_ICR, 7'h01, 3'h3, 4'h1);
    prog(`STTSA_OFS_TX_ICR, 7'h00, 3'h0, 4'hf);
    run(130);
    cmp(rx_1st, 32'd12);
    cmp(rx_n, 32'd8);
    cmp(tx_1st, 32'd1);
    cmp(tx_n, 32'd120);
    cmp({31'h0, txgn}, 32'h1);
    prog(`STTSA_OFS_RX_ICR, 7'h7f, 3'h7, 4'h1);
    prog(`STTSA_OFS_TX_ICR, 7'h00, 3'h0, 4'h0);
    run(1040);
    cmp(rx_1st, 32'd1024);
    cmp(rx_n, 32'd8);
    cmp(tx_n, 32'd1040);
    cmp({30'h0, txgn, rxgn}, 32'h1);
    $display("test frames done");
  endtask

  // A second sync inside an open window starts the count afresh
  task automatic t_restart;
    prog(`STTSA_OFS_RX_ICR, 7'h00, 3'h0, 4'h2);
    rx_n = 0;
    link.frame(8);
    link.frame(30);
    repeat (10) @(posedge sys_clk);
    cmp(rx_1st, 32'd1);
    cmp(rx_n, 32'd23);
    cmp({31'h0, rxgn}, 32'h1);
    $display("test restart done");
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    t_reset();
    t_select();
    t_frames();
    t_restart();
    tally_and_finish();
  end
endmodule
